// ===== rtl/rtd_ctrl_regs.svh
`ifndef RTD_CTRL_REGS_SVH
`define RTD_CTRL_REGS_SVH
// Byte offsets of the register words
`define OFS_CH_SETUP 8'h00
`define OFS_ADC_CFG 8'h04
`define OFS_WIRE_CFG 8'h08
`define OFS_CONV_CTRL 8'h0c
`define OFS_ALERT_STAT 8'h10
`define OFS_ALERT_MASK 8'h14
`define OFS_RESULT 8'h18
`define OFS_CONV_STAT 8'h1c
// Channel function codes
`define FUNC_HIGH_Z 4'h0
`define FUNC_RES_2W 4'h7
`define FUNC_RTD_34W 4'h8
// Input select codes
`define MUX_LF_GND 2'h0
`define MUX_LF_EXT1 2'h1
`define MUX_EXT2_EXT1 2'h2
// Range codes
`define RANGE_12V 3'h0
`define RANGE_2P5V 3'h1
`define RANGE_0P625V 3'h2
`define RANGE_104MV 3'h3
// Excitation current codes
`define CUR_250UA 2'h0
`define CUR_500UA 2'h1
`define CUR_750UA 2'h2
`define CUR_1MA 2'h3
// Field positions
`define ADC_MUX_LSB 0
`define ADC_RANGE_LSB 4
`define WIRE_CUR_LSB 0
`define WIRE_SEL_BIT 4
`define CONV_EN_BIT 0
`define CONVERSION_SEQUENCE_CONTROL_LSB 4
`define SEQ_CONTINUOUS 2'h2
`define SEQ_IDLE 2'h0
`define ALERT_OPEN_BIT 0
`define ALERT_DONE_BIT 1
// Conversion interval, in ns, and its cycle count at 100 MHz
`define CONV_TIME_NS 2000
`define CLK_PERIOD_NS 10
`define CONV_CYCLES (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define RESULT_BITS 16
`endif

// ===== rtl/rtd_ctrl_pkg.sv
package rtd_ctrl_pkg;
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN = 2'b01,
    CONV_DONE = 2'b10
  } conv_state_t;
  typedef logic [3:0] func_t;
  typedef logic [15:0] result_t;
endpackage

// ===== rtl/conv_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
interface conv_bus_if;
  logic start;
  logic run;
  logic done;
  modport ctrl (output start, output run, input done);
  modport seq (input start, input run, output done);
endinterface
`default_nettype wire

// ===== rtl/conv_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "rtd_ctrl_regs.svh"
module conv_sequencer
  import rtd_ctrl_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic nrst, // Async reset
  input wire logic ce, // Clock enable
  conv_bus_if.seq cb // Conversion pacing
);
  localparam int W = 16;
  logic [W-1:0] cnt_r;
  logic done_r;
  wire at_end = (cnt_r == W'(`CONV_CYCLES - 1));

  // Pace conversions; a new start restarts the interval
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end
    else if (ce)
    begin
      done_r <= cb.run && at_end;
      if (cb.start || !cb.run || at_end)
        cnt_r <= '0;
      else
        cnt_r <= cnt_r + 1'b1;
    end
  end
  assign cb.done = done_r;
endmodule
`default_nettype wire

// ===== rtl/rtd_measurement_control.sv
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "rtd_ctrl_regs.svh"
module rtd_measurement_control
  import rtd_ctrl_pkg::*;
(
  input wire logic mclk, // 100 MHz clock
  input wire logic nrst, // Async reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic hsel, // AHB select
  input wire logic [7:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  input wire logic high_sense_over, // High sense node above open threshold
  input wire logic ext_one_over, // External sense one above open threshold
  input wire rtd_ctrl_pkg::result_t adc_sample, // Converter output word
  output rtd_ctrl_pkg::func_t func_out, // Applied channel function
  output logic [1:0] mux_out, // Applied converter input select
  output logic [2:0] range_out, // Applied converter range
  output logic [1:0] current_out, // Applied excitation current
  output logic four_wire_out, // Applied wire count, 1 = 4-wire
  output logic conv_active, // Conversions running
  output logic irq // Interrupt, level
);
  import rtd_ctrl_pkg::*;

  // Conversion pacing lives in a counter of its own
  conv_bus_if cb ();
  conv_sequencer u_seq (.mclk(mclk), .nrst(nrst), .ce(ce), .cb(cb));

  // Host-visible fields
  logic [3:0] func_r;
  logic [1:0] mux_r;
  logic [2:0] range_r;
  logic [1:0] cur_r;
  logic wire_r;
  logic conv_en_r;
  logic [1:0] seq_r;
  logic [1:0] stat_r;
  logic [1:0] mask_r;
  result_t result_r;

  // Conversion and bus state
  conv_state_t state_r;
  conv_state_t state_nxt;
  logic wr_pend_r;
  logic [7:0] addr_r;
  logic [31:0] rdata_nxt;

  // Address phase capture: only whole-word writes matter here
  wire addr_phase = hsel && hready && htrans[1];
  // Writes land in the data phase, the first cycle in which hwdata is valid
  wire wr_now = wr_pend_r;
  wire wr_func = wr_now && (addr_r == `OFS_CH_SETUP);
  wire wr_adc = wr_now && (addr_r == `OFS_ADC_CFG);
  wire wr_wire = wr_now && (addr_r == `OFS_WIRE_CFG);
  wire wr_conv = wr_now && (addr_r == `OFS_CONV_CTRL);
  wire wr_stat = wr_now && (addr_r == `OFS_ALERT_STAT);
  wire wr_mask = wr_now && (addr_r == `OFS_ALERT_MASK);

  // Mode entry means a change of function; rewriting the same code keeps
  // whatever the host has tuned since
  wire [3:0] new_func = hwdata[3:0];
  wire func_change = wr_func && (new_func != func_r);
  wire enter_34w = func_change && (new_func == `FUNC_RTD_34W);
  wire enter_2w = func_change && (new_func == `FUNC_RES_2W);
  // Mode now in effect
  wire in_2w = (func_r == `FUNC_RES_2W);
  wire in_34w = (func_r == `FUNC_RTD_34W);

  // Open-circuit event only counts in 3-wire operation
  // open-circuit detect
  wire open_evt = in_34w && !wire_r && (high_sense_over || ext_one_over);

  // Continuous conversion runs while both control fields ask for it and the function is not high-Z
  // continuous start
  wire run_req = conv_en_r && (seq_r == `SEQ_CONTINUOUS) && (func_r != `FUNC_HIGH_Z);
  // The sequencer counts only while a run is in progress
  assign cb.run = (state_r != CONV_IDLE);
  assign cb.start = (state_r == CONV_IDLE) && run_req;

  // Conversion state
  // A dropped request stops at once rather than at the end of the interval
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      CONV_IDLE: if (run_req) state_nxt = CONV_RUN;
      CONV_RUN: if (!run_req) state_nxt = CONV_IDLE;
        else if (cb.done) state_nxt = CONV_DONE;
      CONV_DONE: state_nxt = run_req ? CONV_RUN : CONV_IDLE;
      default: state_nxt = CONV_IDLE;
    endcase
  end

  // Read mux; unmapped words read as zero
  // Decoded from the address phase so hrdata stands for the whole data phase
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    unique case (haddr)
      `OFS_CH_SETUP: rdata_nxt[3:0] = func_r;
      `OFS_ADC_CFG:
      begin
        rdata_nxt[`ADC_MUX_LSB +: 2] = mux_r;
        rdata_nxt[`ADC_RANGE_LSB +: 3] = range_r;
      end
      `OFS_WIRE_CFG:
      begin
        rdata_nxt[`WIRE_CUR_LSB +: 2] = cur_r;
        rdata_nxt[`WIRE_SEL_BIT] = wire_r;
      end
      `OFS_CONV_CTRL:
      begin
        rdata_nxt[`CONV_EN_BIT] = conv_en_r;
        rdata_nxt[`CONVERSION_SEQUENCE_CONTROL_LSB +: 2] = seq_r;
      end
      `OFS_ALERT_STAT: rdata_nxt[1:0] = stat_r;
      `OFS_ALERT_MASK: rdata_nxt[1:0] = mask_r;
      `OFS_RESULT: rdata_nxt[15:0] = result_r;
      `OFS_CONV_STAT: rdata_nxt[0] = cb.run;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Bus bookkeeping; zero wait states
  // Only whole words are mapped, so hsize is not decoded
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      wr_pend_r <= addr_phase && hwrite;
      if (addr_phase)
        addr_r <= haddr;
      if (addr_phase && !hwrite)
        hrdata <= rdata_nxt;
    end
  end

  // Channel function and wire count
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      func_r <= `FUNC_HIGH_Z;
      wire_r <= 1'b0;
    end
    else if (ce)
    begin
      // Any code is stored; only the 3/4-wire RTD and 2-wire resistance codes carry defaults
      if (wr_func)
        func_r <= new_func;
      if (wr_wire)
        wire_r <= hwdata[`WIRE_SEL_BIT];
    end
  end

  // Range, input and current; mode entry overrides a host write so the
  // fields always read back what the analog side actually uses
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mux_r <= `MUX_LF_GND;
      range_r <= `RANGE_12V;
      cur_r <= `CUR_1MA;
    end
    else if (ce)
    begin
      if (enter_34w)
      begin
        cur_r <= `CUR_1MA;
        range_r <= `RANGE_0P625V;
        mux_r <= `MUX_LF_EXT1;
      end
      else if (enter_2w)
      begin
        range_r <= `RANGE_2P5V;
        mux_r <= `MUX_LF_GND;
      end
      else
      begin
        if (wr_adc && !in_2w)
          range_r <= hwdata[`ADC_RANGE_LSB +: 3];
        // Input select left alone in 2-wire mode; in 3/4-wire the host
        // owns it (and must keep the default for 3-wire use)
        // input default kept
        if (wr_adc && !in_2w)
          mux_r <= hwdata[`ADC_MUX_LSB +: 2];
        // Current stays writable in every mode; only converter fields lock
        // current write
        if (wr_wire)
          cur_r <= hwdata[`WIRE_CUR_LSB +: 2];
      end
    end
  end

  // Conversion control and result capture
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      conv_en_r <= 1'b0;
      seq_r <= `SEQ_IDLE;
      state_r <= CONV_IDLE;
      result_r <= 16'h0000;
    end
    else if (ce)
    begin
      // Both fields are taken in one write, so a start never sees half a command
      if (wr_conv)
      begin
        conv_en_r <= hwdata[`CONV_EN_BIT];
        seq_r <= hwdata[`CONVERSION_SEQUENCE_CONTROL_LSB +: 2];
      end
      state_r <= state_nxt;
      // The result word only moves on a completed conversion
      if (state_r == CONV_RUN && cb.done)
        result_r <= adc_sample;
    end
  end

  // Sticky alerts: set wins over write-one-to-clear
  wire [1:0] evt = {(state_r == CONV_RUN) && cb.done, open_evt};
  wire [1:0] clr = wr_stat ? hwdata[1:0] : 2'h0;
  // The line is fed from the next status so it never lags the flag it reports
  wire [1:0] stat_nxt = (stat_r & ~clr) | evt;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      stat_r <= 2'h0;
      mask_r <= 2'h0;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      stat_r <= stat_nxt;
      if (wr_mask)
        mask_r <= hwdata[1:0];
      irq <= |(stat_nxt & mask_r);
    end
  end

  // Applied settings out, all registered
  // One cycle behind the fields, so the analog side sees whole words only
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      func_out <= `FUNC_HIGH_Z;
      mux_out <= `MUX_LF_GND;
      range_out <= `RANGE_12V;
      current_out <= `CUR_1MA;
      four_wire_out <= 1'b0;
      conv_active <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (ce)
    begin
      func_out <= func_r;
      mux_out <= mux_r;
      range_out <= range_r;
      current_out <= cur_r;
      four_wire_out <= wire_r;
      conv_active <= (state_nxt != CONV_IDLE);
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/rtd_front_model.sv
`timescale 1ns/1ns
`default_nettype none
module rtd_front_model
#(
  parameter logic [15:0] WORD = 16'hc35a
)
(
  input wire logic [1:0] open_cmd, // Bit 0 high node, bit 1 ext one
  output logic high_sense_over, // High node over threshold
  output logic ext_one_over, // Ext one over threshold
  output logic [15:0] adc_sample // Converter word
);
  // A broken lead pushes its node past threshold; an intact lead never does
  assign high_sense_over = open_cmd[0];
  assign ext_one_over = open_cmd[1];
  // Steady word, so any completion edge captures the same result
  assign adc_sample = WORD;
endmodule
`default_nettype wire

// ===== testbench/rtd_measurement_control_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module rtd_measurement_control_monitor
(
  input wire logic mclk, // Clock
  input wire logic nrst, // Reset
  input wire logic hsel, // Select
  input wire logic [7:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic high_sense_over, // High open
  input wire logic ext_one_over, // Ext open
  input wire rtd_ctrl_pkg::func_t func_out, // Function
  input wire logic [1:0] mux_out, // Input
  input wire logic [2:0] range_out, // Range
  input wire logic [1:0] current_out, // Current
  input wire logic four_wire_out, // Wire count
  input wire logic conv_active // Running
);
  import rtd_ctrl_pkg::*;
  logic wp_r;
  logic [7:0] pa_r;
  // Decode of the write data phase and of an alert read
  wire logic take = hsel && hready && htrans[1];
  wire logic rd_alert = take && !hwrite && haddr == 8'h10;
  wire logic wr_func = wp_r && pa_r == 8'h00;
  wire logic wr_adc = wp_r && pa_r == 8'h04;
  wire logic wr_wire = wp_r && pa_r == 8'h08;
  // Data phase follows its accepted address phase
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      wp_r <= 1'b0;
      pa_r <= 8'h00;
    end
    else
    begin
      wp_r <= take && hwrite;
      if (take)
        pa_r <= haddr;
    end
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // Four cycles cover the one-cycle lag of the applied outputs and of the flag
  sequence s_open;
    (func_out == 4'h8 && !four_wire_out && (high_sense_over || ext_one_over)) [*4];
  endsequence
  sequence s_go;
    wr_adc == 1'b0 && wp_r && pa_r == 8'h0c && hwdata[0] && hwdata[5:4] == 2'h2 && func_out != 4'h0;
  endsequence
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  // current follows write
  // Field lands at the data-phase edge; its output copy one edge later
  AST_CURRENT_WR: assert property (wr_wire |=> ##1 current_out == $past(hwdata[1:0], 2))
    else $error("current not applied");
  AST_WIRE_WR: assert property (wr_wire |=> ##1 four_wire_out == $past(hwdata[4], 2))
    else $error("wire count not applied");
  AST_RTD_DEFAULTS: assert property (wr_func && hwdata[3:0] == 4'h8 && func_out != 4'h8 |=>
    ##1 current_out == 2'h3 && range_out == 3'h2 && mux_out == 2'h1)
    else $error("entry defaults missing");
  AST_TWO_WIRE: assert property (func_out == 4'h7 |-> range_out == 3'h1 && mux_out == 2'h0)
    else $error("2-wire setup wrong");
  AST_RANGE_WR: assert property (wr_adc && func_out == 4'h8 |=> ##1 range_out == $past(hwdata[6:4], 2))
    else $error("range not applied");
  AST_OPEN_FLAG: assert property (s_open ##0 rd_alert |=> hrdata[0])
    else $error("open flag missing");
  AST_CONV_GO: assert property (s_go |-> ##[1:3] conv_active)
    else $error("conversions did not start");
endmodule
bind rtd_measurement_control rtd_measurement_control_monitor u_rtd_measurement_control_monitor (
  .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .high_sense_over(high_sense_over), .ext_one_over(ext_one_over), .func_out(func_out),
  .mux_out(mux_out), .range_out(range_out), .current_out(current_out),
  .four_wire_out(four_wire_out), .conv_active(conv_active));
`default_nettype wire

// ===== testbench/rtd_measurement_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module rtd_measurement_control_tb;
  logic mclk, nrst, ce, hsel, hwrite, hreadyout, irq, hso, eoo;
  logic [7:0] haddr;
  logic [1:0] htrans, open_cmd;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] adc_w;
  int err_count, n_tests;
  // Rows: write flag, address, write data or expected read
  logic [40:0] rows [21] = '{
    {1'b0, 8'h00, 32'h0}, {1'b0, 8'h08, 32'h3}, {1'b1, 8'h08, 32'h0}, // power-on values
    {1'b0, 8'h08, 32'h0}, {1'b1, 8'h00, 32'h8}, {1'b0, 8'h04, 32'h21}, // entry
    {1'b0, 8'h08, 32'h3}, {1'b1, 8'h04, 32'h1}, {1'b1, 8'h08, 32'h1}, // 500 uA at 12 V
    {1'b0, 8'h08, 32'h1}, {1'b0, 8'h04, 32'h1}, {1'b1, 8'h08, 32'h2}, // 750 uA
    {1'b0, 8'h08, 32'h2}, {1'b1, 8'h04, 32'h31}, {1'b0, 8'h04, 32'h31}, // 104 mV range
    {1'b1, 8'h08, 32'h13}, {1'b0, 8'h08, 32'h13}, {1'b1, 8'h04, 32'h22}, // 4-wire pair
    {1'b0, 8'h04, 32'h22}, {1'b1, 8'h20, 32'hffffffff}, {1'b0, 8'h20, 32'h0}}; // unmapped
  rtd_measurement_control u_rtd_measurement_control (
    .mclk(mclk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .high_sense_over(hso), .ext_one_over(eoo),
    .adc_sample(adc_w), .func_out(), .mux_out(), .range_out(), .current_out(),
    .four_wire_out(), .conv_active(), .irq(irq));
  rtd_front_model u_rtd_front_model (
    .open_cmd(open_cmd), .high_sense_over(hso), .ext_one_over(eoo), .adc_sample(adc_w));
  // Single transfer; each phase held until ready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge mclk);
    while (hreadyout !== 1'b1)
      @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1)
      @(posedge mclk);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, e);
    chk(rd, e);
  endtask
  task final_report;
    $display("err_count=%0d n_tests=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Whole run is near 360 cycles, so this only fires on a hang
  initial
  begin
    repeat (5000) @(posedge mclk);
    err_count++;
    final_report;
  end
  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    open_cmd = 2'h0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    foreach (rows[i])
      if (rows[i][40])
        wr(rows[i][39:32], rows[i][31:0]);
      else
        rc(rows[i][39:32], rows[i][31:0]);
    open_cmd <= 2'h1;
    repeat (6) @(posedge mclk);
    rc(8'h10, 32'h0);
    wr(8'h08, 32'h3);
    // each node, 3-wire; masked on the first pass, so irq stays low
    for (int k = 1; k < 3; k++)
    begin
      open_cmd <= k[1:0];
      repeat (6) @(posedge mclk);
      rc(8'h10, 32'h1);
      chk({31'h0, irq}, {31'h0, k == 2});
      open_cmd <= 2'h0;
      wr(8'h14, 32'h1);
      wr(8'h10, 32'h1);
      repeat (2) @(posedge mclk);
      rc(8'h10, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    // Clock enable low freezes state: an open lead then leaves no flag
    ce <= 1'b0;
    open_cmd <= 2'h1;
    repeat (6) @(posedge mclk);
    open_cmd <= 2'h0;
    @(posedge mclk);
    ce <= 1'b1;
    rc(8'h10, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // continuous conversions, one per 200 cycles
    wr(8'h0c, 32'h21);
    repeat (210) @(posedge mclk);
    rc(8'h1c, 32'h1);
    rc(8'h10, 32'h2);
    rc(8'h18, 32'hc35a);
    wr(8'h0c, 32'h0);
    repeat (2) @(posedge mclk);
    rc(8'h1c, 32'h0);
    // fixed setup; converter setting writes are refused in this mode
    wr(8'h00, 32'h7);
    rc(8'h04, 32'h10);
    wr(8'h04, 32'h31);
    rc(8'h04, 32'h10);
    // Reset in 2-wire mode, with conversions stopped, returns every field to its power-on value
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rc(8'h00, 32'h0);
    rc(8'h04, 32'h0);
    rc(8'h08, 32'h3);
    final_report;
  end
endmodule
`default_nettype wire
